// ==== irq_status_bit.v ====
// Purpose: one sticky raw interrupt status bit
// Assumes: set and clear are one-cycle pulses
// Notes: a set in the clear cycle is kept
`timescale 1ns/1ps
module irq_status_bit (
	input wire clock, // system clock
	input wire rstn, // synchronous reset, active low
	input wire set, // source event
	input wire clear, // software clear
	output reg status // sticky raw status
);
	// ==========================================================
	// sticky bit
	always @(posedge clock) begin
		if (!rstn) begin
			status <= 1'b0;
		end else begin
			status <= set | (status & ~clear);
		end
	end
endmodule

// ==== rtc_power_control_regs.v ====
// Purpose: register bank of the always-on low-power control unit
// Assumes: processor bus with one-cycle select, answer one cycle later
// Notes: map-only registers are plain storage
// What this block does
// - writing 1 to the snapshot request copies the running timer into readable registers
// - snapshot-valid flag reads set once the readable timer holds the latest capture
// - captured timer is 48 bits: low 32 in one register, high 16 in another
// - writable 48-bit sleep target, low 32 bits then upper 16 bits
// - upper sleep target register also holds the read/write alarm enable
// - nine read/write interrupt enables, all zero after reset
// - nine raw status bits show events whatever the enables say
// - masked status per source is raw status gated by its enable
// - writing 1 to a clear bit clears that source's pending status
// - write-only bits reset whole system, first CPU only, or second CPU only
// - control bit keeps the digital core out of reset in deep sleep
// - control bit forces the digital core into reset in deep sleep
// - sleep enable, refuse and wake controls plus read-only card-link-active
// - separate enables for the coprocessor and touch periodic timers
// - read/write enable that stalls the CPUs
// - minimum slow cycles before the internal fast oscillator may power down
// - slow cycles waited before coprocessor or touch controller start
// - programmable minimum sleep length in slow cycles
// - analog power bit at 1 powers the sub-block up, else down
// - paired force-on and force-off bits for crystal, bias, PLL and its paths
// - per-CPU vector select bits and read-only reset reasons in one register
// - wake filter enable, wake source mask and read-only wake cause
// - watchdog config guarded by a lock register; a write-only kick register
`timescale 1ns/1ps
`include "rtc_power_control_regs_defs.vh"
module rtc_power_control_regs #(
	parameter [31:0] WDT_UNLOCK_KEY = 32'h1234_5678 // arbitrary value
) (
	input wire clock, // system clock, 50 MHz
	input wire rstn, // synchronous reset, active low
	input wire bus_sel, // access strobe, one cycle
	input wire bus_write, // 1 write, 0 read
	input wire [31:0] bus_addr, // byte address
	input wire [31:0] bus_wdata, // write data
	output reg [31:0] bus_rdata, // read data
	output reg bus_ack, // answer pulse
	input wire slow_tick, // one pulse per slow clock cycle
	input wire [8:0] irq_events, // source event pulses
	input wire card_link_active, // card interface active
	input wire deep_sleep, // chip in deep sleep
	input wire osc_on, // fast oscillator running
	input wire coproc_start_req, // coprocessor or touch wants to start
	input wire in_sleep, // sleep in progress
	input wire [5:0] first_cpu_reset_reason, // reset cause of first CPU
	input wire [5:0] second_cpu_reset_reason, // reset cause of second CPU
	input wire [10:0] wake_cause, // wake cause
	output wire irq, // interrupt, level
	output reg soft_system_reset, // pulse
	output reg first_cpu_soft_reset, // pulse
	output reg second_cpu_soft_reset, // pulse
	output wire core_reset_hold, // core held in reset
	output wire [31:0] options_ctrl, // force and bias controls
	output wire crystal_force_on, // crystal force power up
	output wire crystal_force_off, // crystal force power down
	output wire [31:0] analog_power, // analog power-up bits
	output wire sleep_enable, // sleep enable
	output wire sleep_refuse, // sleep refuse
	output wire sleep_wake, // sleep wake
	output wire coproc_timer_enable, // coprocessor timer enable
	output wire touch_timer_enable, // touch timer enable
	output wire cpu_stall, // stall the CPUs
	output wire osc_off_allowed, // fast oscillator may power down
	output wire coproc_go, // coprocessor or touch may start
	output wire sleep_long_enough, // minimum sleep reached
	output wire first_cpu_vector_select, // first CPU vector select
	output wire second_cpu_vector_select, // second CPU vector select
	output wire wake_filter, // filter GPIO wake events
	output wire [10:0] wake_source_mask, // wake source enables
	output reg watchdog_kick // pulse
);
	reg [47:0] rtc_count;
	reg [47:0] snap_value;
	reg snap_valid;
	reg [31:0] options;
	reg [31:0] sleep_low;
	reg [16:0] sleep_high;
	reg [31:0] sleep_state;
	reg stall_en;
	reg [31:0] thresholds;
	reg [31:0] min_sleep;
	reg [31:0] analog;
	reg [1:0] vector_sel;
	reg [31:0] wake_ctrl;
	reg [8:0] irq_enable;
	reg [31:0] wdt_lock;
	reg [31:0] map_store [0:`MAP_ONLY_COUNT-1];
	reg [31:0] next_rdata;
	reg [3:0] map_index;
	reg map_hit;
	wire [8:0] irq_raw;
	wire [8:0] irq_masked;
	wire [8:0] irq_set;
	wire wr;
	wire snap_req;
	wire alarm_hit;
	wire wdt_unlocked;
	wire [8:0] irq_clear;
	wire [7:0] osc_off_min_cycles;
	wire [8:0] coproc_start_delay;
	wire [15:0] min_sleep_length;
	wire [15:0] sleep_target_upper;
	integer i;

	assign wr = bus_sel & bus_write;
	assign snap_req = wr && bus_addr == `ADDR_SNAP_CTRL && bus_wdata[`SNAP_REQ_BIT];
	assign wdt_unlocked = (wdt_lock == WDT_UNLOCK_KEY);

	// ==========================================================
	// field views
	// one clear strobe per source, only while the clear register is written
	assign irq_clear = (wr && bus_addr == `ADDR_IRQ_CLEAR) ? bus_wdata[8:0] : 9'h000;
	assign osc_off_min_cycles = thresholds[31:`THR_OSC_LSB];
	assign coproc_start_delay = thresholds[`THR_OSC_LSB-1:`THR_START_LSB];
	assign min_sleep_length = min_sleep[15:0];
	assign sleep_target_upper = sleep_high[15:0];

	// ==========================================================
	// map-only register index
	always @* begin
		map_hit = 1'b1;
		map_index = 4'h0;
		case (bus_addr)
			`ADDR_XTAL_PAD: map_index = 4'h0;
			`ADDR_SLEEP_REFUSAL: map_index = 4'h1;
			`ADDR_CPU_PERIOD: map_index = 4'h2;
			`ADDR_CLOCK_CONFIG: map_index = 4'h3;
			`ADDR_CARD_REG: map_index = 4'h4;
			`ADDR_WDT_CONFIG1: map_index = 4'h5;
			`ADDR_WDT_CONFIG2: map_index = 4'h6;
			`ADDR_WDT_CONFIG3: map_index = 4'h7;
			`ADDR_WDT_CONFIG4: map_index = 4'h8;
			`ADDR_SW_STALL: map_index = 4'h9;
			`ADDR_PAD_HOLD: map_index = 4'ha;
			`ADDR_SUPPLY_DROP: map_index = 4'hb;
			default: map_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// running timer and snapshot
	// alarm fires on the tick that moves the timer onto the target
	assign alarm_hit = sleep_high[`ALARM_EN_BIT] & slow_tick
		& ((rtc_count + 48'h0000_0000_0001) == {sleep_target_upper, sleep_low});

	always @(posedge clock) begin
		if (!rstn) begin
			rtc_count <= 48'h0000_0000_0000;
			snap_value <= 48'h0000_0000_0000;
			snap_valid <= 1'b0;
		end else begin
			if (slow_tick)
				rtc_count <= rtc_count + 48'h0000_0000_0001;
			if (snap_req) begin
				snap_value <= rtc_count;
				snap_valid <= 1'b1;
			end
		end
	end

	// ==========================================================
	// interrupt status
	assign irq_set = irq_events
		| ({8'h00, alarm_hit} << `IRQ_MAIN_TIMER)
		| ({8'h00, snap_req} << `IRQ_TIME_VALID);

	genvar g;
	generate
		for (g = 0; g < `IRQ_COUNT; g = g + 1) begin : irq_bits
			irq_status_bit u_bit (
				.clock(clock),
				.rstn(rstn),
				.set(irq_set[g]),
				.clear(irq_clear[g]),
				.status(irq_raw[g])
			);
		end
	endgenerate

	assign irq_masked = irq_raw & irq_enable;
	assign irq = |irq_masked;

	// ==========================================================
	// software writes
	always @(posedge clock) begin
		if (!rstn) begin
			options <= 32'h0000_0000;
			sleep_low <= 32'h0000_0000;
			sleep_high <= 17'h0_0000;
			sleep_state <= 32'h0000_0000;
			stall_en <= 1'b0;
			thresholds <= `THR_RESET;
			min_sleep <= `MIN_SLEEP_RESET;
			analog <= 32'h0000_0000;
			vector_sel <= 2'b00;
			wake_ctrl <= 32'h0000_0000;
			irq_enable <= 9'h000;
			wdt_lock <= 32'h0000_0000;
			soft_system_reset <= 1'b0;
			first_cpu_soft_reset <= 1'b0;
			second_cpu_soft_reset <= 1'b0;
			watchdog_kick <= 1'b0;
			for (i = 0; i < `MAP_ONLY_COUNT; i = i + 1)
				map_store[i] <= 32'h0000_0000;
		end else begin
			soft_system_reset <= wr && bus_addr == `ADDR_OPTIONS
				&& bus_wdata[`OPT_SYS_RESET];
			first_cpu_soft_reset <= wr && bus_addr == `ADDR_OPTIONS
				&& bus_wdata[`OPT_FIRST_CPU_RST];
			second_cpu_soft_reset <= wr && bus_addr == `ADDR_OPTIONS
				&& bus_wdata[`OPT_SECOND_CPU_RST];
			watchdog_kick <= wr && bus_addr == `ADDR_WDT_KICK;
			if (wr) begin
				case (bus_addr)
					`ADDR_OPTIONS: options <= bus_wdata & `OPT_RW_MASK;
					`ADDR_SLEEP_LOW: sleep_low <= bus_wdata;
					`ADDR_SLEEP_HIGH: sleep_high <= bus_wdata[16:0];
					`ADDR_SLEEP_STATE: sleep_state <= bus_wdata & `ST_RW_MASK;
					`ADDR_CPU_STALL: stall_en <= bus_wdata[0];
					// bits below the start delay are reserved and read 0
					`ADDR_SLOW_THRESH: thresholds <= bus_wdata & `THR_RW_MASK;
					`ADDR_MIN_SLEEP: min_sleep <= {16'h0000, bus_wdata[15:0]};
					`ADDR_ANALOG_PWR: analog <= bus_wdata & `ANALOG_RW_MASK;
					`ADDR_CPU_RESET: begin
						vector_sel <= {bus_wdata[`RST_FIRST_SEL],
							bus_wdata[`RST_SECOND_SEL]};
					end
					`ADDR_WAKE_STATE: wake_ctrl <= bus_wdata & `WAKE_RW_MASK;
					`ADDR_IRQ_ENABLE: irq_enable <= bus_wdata[8:0];
					`ADDR_WDT_LOCK: wdt_lock <= bus_wdata;
					default: begin
						// watchdog config only moves while the lock holds the key
						if (map_hit && (!(map_index >= 4'h5 && map_index <= 4'h8)
								|| wdt_unlocked))
							map_store[map_index] <= bus_wdata;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// reads, answered one cycle after the strobe
	always @* begin
		next_rdata = 32'h0000_0000;
		case (bus_addr)
			`ADDR_OPTIONS: next_rdata = options;
			`ADDR_SLEEP_LOW: next_rdata = sleep_low;
			`ADDR_SLEEP_HIGH: next_rdata = {15'h0000, sleep_high};
			`ADDR_SNAP_CTRL: next_rdata = {1'b0, snap_valid, 30'h0000_0000};
			`ADDR_TIME_LOW: next_rdata = snap_value[31:0];
			`ADDR_TIME_HIGH: next_rdata = {16'h0000, snap_value[47:32]};
			// live inputs are merged in at read time, never stored
			`ADDR_SLEEP_STATE: begin
				next_rdata = sleep_state;
				next_rdata[`ST_CARD_ACTIVE] = card_link_active;
			end
			`ADDR_CPU_STALL: next_rdata = {31'h0000_0000, stall_en};
			`ADDR_SLOW_THRESH: next_rdata = thresholds;
			`ADDR_MIN_SLEEP: next_rdata = min_sleep;
			`ADDR_ANALOG_PWR: next_rdata = analog;
			`ADDR_CPU_RESET: begin
				next_rdata = {18'h0_0000, vector_sel, second_cpu_reset_reason,
					first_cpu_reset_reason};
			end
			`ADDR_WAKE_STATE: next_rdata = wake_ctrl | {21'h00_0000, wake_cause};
			`ADDR_IRQ_ENABLE: next_rdata = {23'h00_0000, irq_enable};
			`ADDR_IRQ_RAW: next_rdata = {23'h00_0000, irq_raw};
			`ADDR_IRQ_MASKED: next_rdata = {23'h00_0000, irq_masked};
			`ADDR_WDT_LOCK: next_rdata = wdt_lock;
			default: begin
				if (map_hit)
					next_rdata = map_store[map_index];
			end
		endcase
	end

	always @(posedge clock) begin
		if (!rstn) begin
			bus_rdata <= 32'h0000_0000;
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_sel;
			if (bus_sel && !bus_write)
				bus_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// slow-clock waits
	// each wait restarts from zero when its arm input drops
	slow_cycle_wait #(.WIDTH(8)) u_osc_wait (
		.clock(clock),
		.rstn(rstn),
		.arm(osc_on),
		.tick(slow_tick),
		.limit(osc_off_min_cycles),
		.done(osc_off_allowed)
	);

	slow_cycle_wait #(.WIDTH(9)) u_start_wait (
		.clock(clock),
		.rstn(rstn),
		.arm(coproc_start_req),
		.tick(slow_tick),
		.limit(coproc_start_delay),
		.done(coproc_go)
	);

	slow_cycle_wait #(.WIDTH(16)) u_sleep_wait (
		.clock(clock),
		.rstn(rstn),
		.arm(in_sleep),
		.tick(slow_tick),
		.limit(min_sleep_length),
		.done(sleep_long_enough)
	);

	// ==========================================================
	// control outputs
	// force-reset beats hold-out when both are set
	assign core_reset_hold = deep_sleep & (options[`OPT_CORE_FORCE_RST]
		| ~options[`OPT_CORE_HOLD_OUT]);
	assign options_ctrl = options;
	assign crystal_force_on = options[`OPT_CRYSTAL_ON];
	assign crystal_force_off = options[`OPT_CRYSTAL_OFF];
	assign analog_power = analog;
	assign sleep_enable = sleep_state[`ST_SLEEP_EN];
	assign sleep_refuse = sleep_state[`ST_SLEEP_REFUSE];
	assign sleep_wake = sleep_state[`ST_SLEEP_WAKE];
	assign coproc_timer_enable = sleep_state[`ST_COPROC_TMR];
	assign touch_timer_enable = sleep_state[`ST_TOUCH_TMR];
	assign cpu_stall = stall_en;
	assign first_cpu_vector_select = vector_sel[1];
	assign second_cpu_vector_select = vector_sel[0];
	assign wake_filter = wake_ctrl[`WAKE_FILTER];
	assign wake_source_mask = wake_ctrl[21:11];
endmodule

// ==== rtc_power_control_regs_chk.sv ====
// Purpose: concurrent checks on the ports of the low-power control register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to every instance by the bind at the foot of this file
`timescale 1ns/1ps
`include "rtc_power_control_regs_defs.vh"
module rtc_power_control_regs_chk (
	input wire clock, // system clock
	input wire rstn, // reset, active low
	input wire bus_sel, // access strobe
	input wire bus_write, // write flag
	input wire [31:0] bus_addr, // byte address
	input wire [31:0] bus_wdata, // write data
	input wire [8:0] irq_events, // source events
	input wire deep_sleep, // deep sleep level
	input wire irq, // interrupt
	input wire soft_system_reset, // pulse
	input wire first_cpu_soft_reset, // pulse
	input wire second_cpu_soft_reset, // pulse
	input wire core_reset_hold, // core in reset
	input wire [31:0] options_ctrl, // options copy
	input wire crystal_force_on, // crystal on
	input wire crystal_force_off, // crystal off
	input wire [31:0] analog_power, // analog bits
	input wire sleep_enable, // sleep enable
	input wire coproc_timer_enable, // coprocessor timer
	input wire touch_timer_enable, // touch timer
	input wire cpu_stall, // stall
	input wire first_cpu_vector_select, // vector select
	input wire [10:0] wake_source_mask, // wake sources
	input wire watchdog_kick, // kick pulse
	input wire slow_tick, // slow clock tick
	input wire sleep_refuse, // sleep refuse
	input wire sleep_wake, // sleep wake
	input wire second_cpu_vector_select, // vector select
	input wire wake_filter // wake filter
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire wr = bus_sel && bus_write;
	wire wr_opt = wr && bus_addr == `ADDR_OPTIONS;
	// ==========================================================
	// write-only pulses
	sys_reset_pulse_a: assert property (
		soft_system_reset == $past(wr_opt && bus_wdata[`OPT_SYS_RESET])) else $error("system reset pulse wrong");
	cpu_reset_pulse_a: assert property (
		{first_cpu_soft_reset, second_cpu_soft_reset} == $past({2{wr_opt}} & bus_wdata[5:4]))
		else $error("cpu reset pulse wrong");
	kick_pulse_a: assert property (
		watchdog_kick == $past(wr && bus_addr == `ADDR_WDT_KICK)) else $error("kick pulse wrong");
	// ==========================================================
	// control levels
	core_hold_a: assert property (
		core_reset_hold == (deep_sleep && (options_ctrl[28] || !options_ctrl[29])))
		else $error("core reset hold wrong");
	options_hold_a: assert property (!wr_opt |=> $stable(options_ctrl))
		else $error("options changed without write");
	crystal_pair_a: assert property (wr_opt |=>
		{crystal_force_on, crystal_force_off} == $past(bus_wdata[23:22])) else $error("crystal bits wrong");
	sleep_ctrl_a: assert property (wr && bus_addr == `ADDR_SLEEP_STATE |=>
		{sleep_enable, sleep_refuse, sleep_wake, coproc_timer_enable, touch_timer_enable}
		== $past({bus_wdata[31:29], bus_wdata[24:23]})) else $error("sleep controls wrong");
	stall_a: assert property (wr && bus_addr == `ADDR_CPU_STALL |=>
		cpu_stall == $past(bus_wdata[0])) else $error("stall bit wrong");
	analog_a: assert property (wr && bus_addr == `ADDR_ANALOG_PWR |=>
		analog_power == ($past(bus_wdata) & `ANALOG_RW_MASK)) else $error("analog bits wrong");
	wake_mask_a: assert property (wr && bus_addr == `ADDR_WAKE_STATE |=>
		{wake_filter, wake_source_mask} == $past(bus_wdata[22:11])) else $error("wake mask wrong");
	vector_sel_a: assert property (wr && bus_addr == `ADDR_CPU_RESET |=>
		{first_cpu_vector_select, second_cpu_vector_select} == $past(bus_wdata[13:12]))
		else $error("vector select wrong");
	// ==========================================================
	// interrupt line
	irq_rise_a: assert property ($rose(irq) |-> $past(|irq_events || wr || slow_tick))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(wr))
		else $error("irq fell without write");
endmodule
bind rtc_power_control_regs rtc_power_control_regs_chk chk_i (.clock, .rstn, .bus_sel,
	.bus_write, .bus_addr, .bus_wdata, .irq_events, .deep_sleep, .irq, .soft_system_reset,
	.first_cpu_soft_reset, .second_cpu_soft_reset, .core_reset_hold, .options_ctrl,
	.crystal_force_on, .crystal_force_off, .analog_power, .sleep_enable, .coproc_timer_enable,
	.touch_timer_enable, .cpu_stall, .first_cpu_vector_select, .wake_source_mask,
	.watchdog_kick, .slow_tick, .sleep_refuse, .sleep_wake, .second_cpu_vector_select,
	.wake_filter);

// ==== rtc_power_control_regs_defs.vh ====
// Purpose: offsets, field positions and reset values of the low-power control registers
// Assumes: byte addresses on the processor bus, 32-bit data
// Notes: included by the register bank, its checker and its bench
`ifndef RTC_POWER_CONTROL_REGS_DEFS_VH
`define RTC_POWER_CONTROL_REGS_DEFS_VH

// ==========================================================
// register addresses
`define ADDR_OPTIONS 32'h3ff4_8000
`define ADDR_SLEEP_LOW 32'h3ff4_8004
`define ADDR_SLEEP_HIGH 32'h3ff4_8008
`define ADDR_SNAP_CTRL 32'h3ff4_800c
`define ADDR_TIME_LOW 32'h3ff4_8010
`define ADDR_TIME_HIGH 32'h3ff4_8014
`define ADDR_SLEEP_STATE 32'h3ff4_8018
`define ADDR_CPU_STALL 32'h3ff4_801c
`define ADDR_SLOW_THRESH 32'h3ff4_8020
`define ADDR_MIN_SLEEP 32'h3ff4_802c
`define ADDR_ANALOG_PWR 32'h3ff4_8030
`define ADDR_CPU_RESET 32'h3ff4_8034
`define ADDR_WAKE_STATE 32'h3ff4_8038
`define ADDR_IRQ_ENABLE 32'h3ff4_803c
`define ADDR_IRQ_RAW 32'h3ff4_8040
`define ADDR_IRQ_MASKED 32'h3ff4_8044
`define ADDR_IRQ_CLEAR 32'h3ff4_8048
`define ADDR_XTAL_PAD 32'h3ff4_805c
`define ADDR_SLEEP_REFUSAL 32'h3ff4_8064
`define ADDR_CPU_PERIOD 32'h3ff4_8068
`define ADDR_CLOCK_CONFIG 32'h3ff4_8070
`define ADDR_CARD_REG 32'h3ff4_8074
`define ADDR_WDT_CONFIG1 32'h3ff4_8090
`define ADDR_WDT_CONFIG2 32'h3ff4_8094
`define ADDR_WDT_CONFIG3 32'h3ff4_8098
`define ADDR_WDT_CONFIG4 32'h3ff4_809c
`define ADDR_WDT_KICK 32'h3ff4_80a0
`define ADDR_WDT_LOCK 32'h3ff4_80a4
`define ADDR_SW_STALL 32'h3ff4_80ac
`define ADDR_PAD_HOLD 32'h3ff4_80c8
`define ADDR_SUPPLY_DROP 32'h3ff4_80d4

// ==========================================================
// options_and_resets fields
`define OPT_SYS_RESET 31
`define OPT_CORE_HOLD_OUT 29
`define OPT_CORE_FORCE_RST 28
`define OPT_CRYSTAL_ON 23
`define OPT_CRYSTAL_OFF 22
`define OPT_FIRST_CPU_RST 5
`define OPT_SECOND_CPU_RST 4
`define OPT_RW_MASK 32'h3fff_ffcf

// ==========================================================
// other fields
`define ALARM_EN_BIT 16
`define SNAP_REQ_BIT 31
`define SNAP_VALID_BIT 30
`define ST_SLEEP_EN 31
`define ST_SLEEP_REFUSE 30
`define ST_SLEEP_WAKE 29
`define ST_CARD_ACTIVE 28
`define ST_COPROC_TMR 24
`define ST_TOUCH_TMR 23
`define ST_RW_MASK 32'he180_0000
`define THR_OSC_LSB 24
`define THR_START_LSB 15
`define THR_RESET 32'h0108_0000
`define THR_RW_MASK 32'hffff_8000
`define MIN_SLEEP_RESET 32'h0000_0080
`define ANALOG_RW_MASK 32'h0fe0_0000
`define RST_FIRST_SEL 13
`define RST_SECOND_SEL 12
`define WAKE_FILTER 22
`define WAKE_MASK_LSB 11
`define WAKE_RW_MASK 32'h007f_f800
`define IRQ_COUNT 9
`define IRQ_MAIN_TIMER 0
`define IRQ_TIME_VALID 4
`define MAP_ONLY_COUNT 12

`endif

// ==== slow_cycle_wait.v ====
// Purpose: counts slow clock ticks while armed, flags when a threshold is reached
// Assumes: tick is a one-cycle pulse per slow clock cycle
// Notes: disarming restarts the count
`timescale 1ns/1ps
module slow_cycle_wait #(
	parameter WIDTH = 16
) (
	input wire clock, // system clock
	input wire rstn, // synchronous reset, active low
	input wire arm, // level, count while high
	input wire tick, // slow clock tick
	input wire [WIDTH-1:0] limit, // cycles to wait
	output reg done // threshold reached
);
	reg [WIDTH-1:0] count;

	// ==========================================================
	// counter
	always @(posedge clock) begin
		if (!rstn || !arm) begin
			count <= {WIDTH{1'b0}};
			done <= 1'b0;
		end else begin
			// saturate so a long wait never wraps back below the limit
			if (tick && count != {WIDTH{1'b1}})
				count <= count + 1'b1;
			done <= (count >= limit);
		end
	end
endmodule

// ==== tb_rtc_power_control_regs.sv ====
// Purpose: self-checking bench for the low-power control register bank
// Assumes: one access at a time, answer one cycle after the strobe
// Notes: live read-only inputs are fixed random values for the whole run
`timescale 1ns/1ps
`include "rtc_power_control_regs_defs.vh"
module tb_rtc_power_control_regs;
	localparam [31:0] KEY = 32'h1234_5678; // arbitrary value
	logic clock = 0, rstn = 0, bus_sel = 0, bus_write = 0, slow_tick = 0;
	logic card_link_active = 0, deep_sleep = 0, osc_on = 0, coproc_start_req = 0, in_sleep = 0;
	logic [31:0] bus_addr = 0, bus_wdata = 0;
	logic [8:0] irq_events = 0;
	logic [5:0] first_cpu_reset_reason = 0, second_cpu_reset_reason = 0;
	logic [10:0] wake_cause = 0;
	wire [31:0] bus_rdata, options_ctrl, analog_power;
	wire bus_ack, irq, soft_system_reset, first_cpu_soft_reset, second_cpu_soft_reset;
	wire core_reset_hold, crystal_force_on, crystal_force_off, sleep_enable, sleep_refuse;
	wire sleep_wake, coproc_timer_enable, touch_timer_enable, cpu_stall, osc_off_allowed;
	wire coproc_go, sleep_long_enough, first_cpu_vector_select, second_cpu_vector_select;
	wire wake_filter, watchdog_kick;
	wire [10:0] wake_source_mask;
	logic [31:0] seed = 32'hfc6c, rd_v, w, m, a;
	logic [47:0] tmr = 0, tgt;
	logic [8:0] raw = 0;
	integer miscompares = 0, checks_done = 0, i, k;
	logic [7:0] offs [0:30] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h5c, 8'h64, 8'h68, 8'h70,
		8'h74, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'hac, 8'hc8, 8'hd4, 8'h24};
	// writable bits; locked watchdog settings and the unmapped hole keep nothing
	logic [31:0] msk [0:30] = '{32'h3fff_ffcf, 32'hffff_ffff, 32'h0001_ffff, 32'h0000_0000,
		32'h0000_0000, 32'he180_0000, 32'h0000_0001, 32'hffff_8000, 32'h0000_ffff,
		32'h0fe0_0000, 32'h0000_3000, 32'h007f_f800, 32'h0000_01ff, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		32'hffff_ffff, 32'h0000_0000};
	rtc_power_control_regs #(.WDT_UNLOCK_KEY(KEY)) dut (.clock, .rstn, .bus_sel, .bus_write,
		.bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .slow_tick, .irq_events, .card_link_active,
		.deep_sleep, .osc_on, .coproc_start_req, .in_sleep, .first_cpu_reset_reason,
		.second_cpu_reset_reason, .wake_cause, .irq, .soft_system_reset, .first_cpu_soft_reset,
		.second_cpu_soft_reset, .core_reset_hold, .options_ctrl, .crystal_force_on,
		.crystal_force_off, .analog_power, .sleep_enable, .sleep_refuse, .sleep_wake,
		.coproc_timer_enable, .touch_timer_enable, .cpu_stall, .osc_off_allowed, .coproc_go,
		.sleep_long_enough, .first_cpu_vector_select, .second_cpu_vector_select, .wake_filter,
		.wake_source_mask, .watchdog_kick);
	initial forever #10 clock = ~clock;
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] live(input logic [31:0] ad);
		if (ad == `ADDR_SLEEP_STATE) return card_link_active ? 32'h1000_0000 : 32'h0000_0000;
		if (ad == `ADDR_CPU_RESET) return {20'h0_0000, second_cpu_reset_reason,
			first_cpu_reset_reason};
		if (ad == `ADDR_WAKE_STATE) return {21'h00_0000, wake_cause};
		return 32'h0000_0000;
	endfunction
	task automatic close_out();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until the edge that takes it; answer looked at one cycle later
	task automatic acc(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		integer n;
		@(posedge clock);
		bus_sel <= 1'b1;
		bus_write <= wr;
		bus_addr <= ad;
		bus_wdata <= wd;
		@(posedge clock);
		bus_sel <= 1'b0;
		#1;
		n = 0;
		while (bus_ack !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 4) begin
			miscompares++;
			close_out();
		end
		rd_v = bus_rdata;
	endtask
	task automatic rd(input logic [31:0] ad, input logic [31:0] ex);
		acc(1'b0, ad, 32'h0000_0000);
		chk(rd_v, ex);
	endtask
	task automatic tick();
		@(posedge clock);
		slow_tick <= 1'b1;
		tmr = tmr + 1;
		@(posedge clock);
		slow_tick <= 1'b0;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		@(posedge clock);
		w = xs();
		{card_link_active, wake_cause, second_cpu_reset_reason, first_cpu_reset_reason} <= w[23:0];
		repeat (7) @(posedge clock);
		rstn <= 1'b1;
		for (i = 0; i < 31; i++) begin
			a = {24'h3f_f480, offs[i]};
			rd(a, live(a) | (a == `ADDR_SLOW_THRESH ? `THR_RESET :
				a == `ADDR_MIN_SLEEP ? `MIN_SLEEP_RESET : 32'h0000_0000));
			w = xs();
			// snapshot control is not among these offsets and is exercised later; the time-valid source stays quiet here
			if (a == `ADDR_SNAP_CTRL) w[`SNAP_REQ_BIT] = 1'b0;
			@(posedge clock);
			deep_sleep <= w[1];
			acc(1'b1, a, w);
			rd(a, (w & msk[i]) | live(a));
		end
		acc(1'b1, `ADDR_WDT_LOCK, KEY);
		w = xs();
		acc(1'b1, `ADDR_WDT_CONFIG2, w);
		rd(`ADDR_WDT_CONFIG2, w);
		for (k = 0; k < 2; k++) begin
			repeat (k + 2) tick();
			acc(1'b1, `ADDR_SNAP_CTRL, 32'h8000_0000);
			rd(`ADDR_TIME_LOW, tmr[31:0]);
			rd(`ADDR_TIME_HIGH, {16'h0000, tmr[47:32]});
			rd(`ADDR_SNAP_CTRL, 32'h4000_0000);
		end
		raw[4] = 1'b1;
		tgt = tmr + 2;
		acc(1'b1, `ADDR_SLEEP_LOW, tgt[31:0]);
		acc(1'b1, `ADDR_SLEEP_HIGH, {15'h0000, 1'b1, tgt[47:32]});
		tick();
		rd(`ADDR_IRQ_RAW, {23'h00_0000, raw});
		tick();
		raw[0] = 1'b1;
		rd(`ADDR_IRQ_RAW, {23'h00_0000, raw});
		acc(1'b1, `ADDR_SLEEP_HIGH, 32'h0000_0000);
		acc(1'b1, `ADDR_SLOW_THRESH, 32'h0201_8000);
		acc(1'b1, `ADDR_MIN_SLEEP, 32'h0000_0004);
		@(posedge clock);
		{osc_on, coproc_start_req, in_sleep} <= 3'b111;
		for (k = 0; k < 7; k++) begin
			if (k == 6) begin
				@(posedge clock);
				{osc_on, coproc_start_req, in_sleep} <= 3'b000;
			end else if (k > 0) tick();
			repeat (2) @(posedge clock);
			#1;
			w = {29'h0000_0000, k >= 2 && k < 6, k >= 3 && k < 6, k >= 4 && k < 6};
			chk({29'h0000_0000, osc_off_allowed, coproc_go, sleep_long_enough}, w);
		end
		acc(1'b1, `ADDR_IRQ_CLEAR, 32'h0000_01ff);
		raw = 9'h000;
		rd(`ADDR_IRQ_RAW, 32'h0000_0000);
		for (k = 0; k < 10; k++) begin
			w = xs();
			m = xs();
			acc(1'b1, `ADDR_IRQ_ENABLE, {23'h00_0000, w[8:0]});
			@(posedge clock);
			irq_events <= m[8:0];
			@(posedge clock);
			irq_events <= 9'h000;
			raw = raw | m[8:0];
			rd(`ADDR_IRQ_RAW, {23'h00_0000, raw});
			rd(`ADDR_IRQ_MASKED, {23'h00_0000, raw & w[8:0]});
			chk({31'h0000_0000, irq}, {31'h0000_0000, |(raw & w[8:0])});
			a = xs();
			acc(1'b1, `ADDR_IRQ_CLEAR, {23'h00_0000, a[8:0]});
			raw = raw & ~a[8:0];
			rd(`ADDR_IRQ_RAW, {23'h00_0000, raw});
			chk({31'h0000_0000, irq}, {31'h0000_0000, |(raw & w[8:0])});
		end
		close_out();
	end
endmodule
